// *** verilog/aclink_modem_pkg.sv ***
package aclink_modem_pkg;
  // ----------------------------------------------------------------
  // frame geometry
  // ----------------------------------------------------------------
  localparam int unsigned TAG_BITS      = 16;            // slot 0 length
  localparam int unsigned SLOT_BITS     = 20;            // data slot length
  localparam int unsigned FRAME_BITS    = 256;           // bits per frame
  localparam logic [8:0]  SLOT1_START   = 9'h010;        // first bit of slot 1
  localparam logic [8:0]  SLOT2_START   = 9'h024;        // first bit of slot 2
  localparam logic [8:0]  SLOT5_START   = 9'h060;        // first bit of slot 5
  localparam logic [8:0]  SLOT12_START  = 9'h0EC;        // first bit of slot 12
  // ----------------------------------------------------------------
  // slot 0 tag bit positions
  // ----------------------------------------------------------------
  localparam int unsigned TAG_FRAME     = 15;            // frame valid / ready
  localparam int unsigned TAG_SLOT1     = 14;            // slot 1 valid
  localparam int unsigned TAG_SLOT2     = 13;            // slot 2 valid
  localparam int unsigned TAG_SLOT5     = 10;            // slot 5 valid
  localparam int unsigned TAG_SLOT12    = 3;             // slot 12 valid
  // ----------------------------------------------------------------
  // slot 1 / 2 field positions
  // ----------------------------------------------------------------
  localparam int unsigned CMD_RW        = 19;            // 1 read, 0 write
  localparam int unsigned CMD_IDX_HI    = 18;            // index msb
  localparam int unsigned REQ_LINE1     = 9;             // line 1 request bit
  localparam int unsigned REQ_LINE2     = 4;             // line 2 request bit
  // ----------------------------------------------------------------
  // codec register indices (7-bit byte address)
  // ----------------------------------------------------------------
  localparam logic [6:0]  REG_POWER     = 7'h3E;         // modem power down
  localparam logic [6:0]  REG_LINK      = 7'h56;         // link halt control
  localparam int unsigned PD_ADC_A      = 10;            // adc_powerdown_a
  localparam int unsigned PD_DAC_A      = 11;            // dac_powerdown_a
  localparam int unsigned PD_ADC_B      = 12;            // adc_powerdown_b
  localparam int unsigned PD_DAC_B      = 13;            // dac_powerdown_b
  localparam int unsigned LINK_HALT     = 12;            // link_halt_request
  localparam logic [15:0] REG_RESET_VAL = 16'h0000;      // register reset value
  localparam logic [1:0]  SEC_CODEC_ID  = 2'h1;          // secondary id
  // ----------------------------------------------------------------
  // axi register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  AXI_CTRL      = 8'h00;         // codec ready bit
  localparam logic [7:0]  AXI_STATUS    = 8'h04;         // line status
  localparam logic [7:0]  AXI_ADC       = 8'h08;         // adc sample in
  localparam logic [7:0]  AXI_DAC       = 8'h0C;         // last dac sample
  localparam logic [1:0]  RESP_OKAY     = 2'h0;          // axi okay
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;          // axi slave error
endpackage : aclink_modem_pkg

// *** verilog/aclink_modem_slots.sv ***
`timescale 1ns/1ps
module aclink_modem_slots
  import aclink_modem_pkg::*;
#(
  parameter int unsigned NUM_REGS = 64                   // register count
) (
  input  wire logic        aclk,                         // system clock
  input  wire logic        aresetn,                      // sync reset, low
  input  wire logic        bit_clk,                      // link bit clock
  input  wire logic        sync,                         // frame sync
  input  wire logic        sdata_out,                    // serial from ctrl
  output logic             sdata_in,                     // serial to ctrl
  output logic             line_off_hook,                // slot 12 bit 0
  output logic             caller_info_path_enable,      // slot 12 bit 2
  output logic             line_iface_interrupt,         // slot 12 bit 7
  output logic             gp_pin_a_out,                 // gpio a level
  output logic             gp_pin_a_oe_n,                // gpio a drive, low
  output logic             gp_pin_b_out,                 // gpio b level
  output logic             gp_pin_b_oe_n,                // gpio b drive, low
  input  wire logic        gp_pin_a_in,                  // gpio a pin
  input  wire logic        gp_pin_b_in,                  // gpio b pin
  input  wire logic        ring_detected,                // slot 12 bit 1
  input  wire logic        loop_current_delta,           // slot 12 bit 3
  input  wire logic        loop_current_overload,        // slot 12 bit 6
  input  wire logic        line_side_frame_detect,       // optional bit 1
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] clk_sr;                                    // bit clock stages
  logic [2:0] sync_sr;                                   // frame sync stages
  logic [2:0] sdo_sr;                                    // serial data stages
  logic [2:0] gpa_sr;                                    // gpio a stages
  logic [2:0] gpb_sr;                                    // gpio b stages
  logic       clk_lvl;                                   // filtered bit clock
  logic       sync_lvl;                                  // filtered sync
  logic       sdo_lvl;                                   // filtered data
  logic       gpa_lvl;                                   // filtered gpio a
  logic       gpb_lvl;                                   // filtered gpio b
  logic [11:0] line_sr;                                  // line status pins, three stages of four
  logic [3:0]  line_lvl;                                 // filtered ring, delta, overload, detect

  // three stages, a change counts once stages two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_sr   <= 3'h0;
      sync_sr  <= 3'h0;
      sdo_sr   <= 3'h0;
      gpa_sr   <= 3'h0;
      gpb_sr   <= 3'h0;
      clk_lvl  <= 1'b0;
      sync_lvl <= 1'b0;
      sdo_lvl  <= 1'b0;
      gpa_lvl  <= 1'b0;
      gpb_lvl  <= 1'b0;
      line_sr  <= 12'h000;
      line_lvl <= 4'h0;
    end else begin
      clk_sr  <= {clk_sr[1:0], bit_clk};
      sync_sr <= {sync_sr[1:0], sync};
      sdo_sr  <= {sdo_sr[1:0], sdata_out};
      gpa_sr  <= {gpa_sr[1:0], gp_pin_a_in};
      gpb_sr  <= {gpb_sr[1:0], gp_pin_b_in};
      if (clk_sr[1] == clk_sr[2]) clk_lvl <= clk_sr[2];
      if (sync_sr[1] == sync_sr[2]) sync_lvl <= sync_sr[2];
      if (sdo_sr[1] == sdo_sr[2]) sdo_lvl <= sdo_sr[2];
      if (gpa_sr[1] == gpa_sr[2]) gpa_lvl <= gpa_sr[2];
      if (gpb_sr[1] == gpb_sr[2]) gpb_lvl <= gpb_sr[2];
      line_sr  <= {line_sr[7:0], line_side_frame_detect, loop_current_overload, loop_current_delta, ring_detected};
      line_lvl <= (line_sr[7:4] & line_sr[11:8]) | (line_lvl & (line_sr[7:4] | line_sr[11:8]));
    end
  end

  // edges of the filtered bit clock
  logic clk_prev;                                        // last clock level
  logic fall;                                            // sample point
  logic rise;                                            // launch point
  always_ff @(posedge aclk) begin
    if (!aresetn) clk_prev <= 1'b0;
    else          clk_prev <= clk_lvl;
  end
  assign fall = clk_prev & ~clk_lvl;
  assign rise = ~clk_prev & clk_lvl;

  // ----------------------------------------------------------------
  // receive framing
  // ----------------------------------------------------------------
  logic        sync_prev;                                // sync at last fall
  logic [8:0]  rx_pos;                                   // bit position
  logic        rx_run;                                   // frame seen
  logic        frame_start;                              // sync rise at fall
  logic [15:0] rx_tag;                                   // received slot 0
  logic [19:0] rx_sh;                                    // slot shifter
  logic [19:0] rx_cmd;                                   // latched slot 1
  logic        cmd_pend;                                 // command for next frame
  logic        cmd_rd;                                   // pending is a read
  logic [6:0]  cmd_idx;                                  // pending index
  logic [15:0] dac_sample;                               // last slot 5 sample
  logic [15:0] gp_ctrl;                                  // last slot 12 word
  logic        addressed;                                // frame is for us

  // sync rising seen on a falling bit clock edge starts a frame
  assign frame_start = fall & sync_lvl & ~sync_prev;
  assign addressed   = rx_tag[TAG_FRAME] && (rx_tag[1:0] == SEC_CODEC_ID);

  // position counter; bit 0 is first tag bit, sampled on next fall
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_prev <= 1'b0;
      rx_pos    <= 9'h000;
      rx_run    <= 1'b0;
    end else if (fall) begin
      sync_prev <= sync_lvl;
      if (frame_start) begin
        rx_pos <= 9'h000;
        rx_run <= 1'b1;
      end else if (rx_run && rx_pos != 9'h1FF) begin
        rx_pos <= rx_pos + 9'h001;
      end
    end
  end

  // shift in serial data msb first, one bit per falling edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_tag <= 16'h0000;
      rx_sh  <= 20'h00000;
    end else if (fall && rx_run && !frame_start) begin
      rx_sh <= {rx_sh[18:0], sdo_lvl};
      if (rx_pos < 9'(TAG_BITS)) rx_tag <= {rx_tag[14:0], sdo_lvl};
    end
  end

  // slot capture: slot N ends when position equals start + 20; slot 12 on its own last bit
  logic slot1_end, slot2_end, slot5_end, slot12_end;    // capture strobes
  assign slot1_end  = fall && rx_run && !frame_start && rx_pos == SLOT2_START;
  assign slot2_end  = fall && rx_run && !frame_start && rx_pos == SLOT2_START + 9'(SLOT_BITS);
  assign slot5_end  = fall && rx_run && !frame_start && rx_pos == SLOT5_START + 9'(SLOT_BITS);
  assign slot12_end = fall && rx_run && !frame_start && rx_pos == SLOT12_START + 9'(SLOT_BITS) - 9'h001;

  // ----------------------------------------------------------------
  // codec register file
  // ----------------------------------------------------------------
  logic [15:0] regs [NUM_REGS];                          // even registers
  logic        wr_go;                                    // write strobe
  assign wr_go = slot2_end && addressed && !rx_cmd[CMD_RW] && !rx_cmd[12];

  // each entry loads only on a completed, addressed write
  for (genvar i = 0; i < NUM_REGS; i++) begin : g_reg
    always_ff @(posedge aclk) begin
      if (!aresetn)                                     regs[i] <= REG_RESET_VAL;
      else if (wr_go && rx_cmd[18:13] == 6'(i))         regs[i] <= rx_sh[19:4];
    end
  end

  // command decode: latch slot 1, arm status for the next frame
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_cmd   <= 20'h00000;
      cmd_pend <= 1'b0;
      cmd_rd   <= 1'b0;
      cmd_idx  <= 7'h00;
    end else begin
      if (slot1_end) rx_cmd <= rx_sh;
      if (frame_start) cmd_pend <= 1'b0;
      if (slot2_end && addressed) begin
        cmd_pend <= 1'b1;
        cmd_rd   <= rx_cmd[CMD_RW];
        cmd_idx  <= rx_cmd[18:12];
      end
    end
  end

  // slot 5 and slot 12 payload, only when tagged in a valid frame
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dac_sample <= 16'h0000;
      gp_ctrl    <= 16'h0000;
    end else begin
      if (slot5_end && rx_tag[TAG_FRAME] && rx_tag[TAG_SLOT5]) dac_sample <= rx_sh[19:4];
      if (slot12_end && rx_tag[TAG_FRAME] && rx_tag[TAG_SLOT12]) gp_ctrl <= rx_sh[18:3]; // last bit not yet shifted
    end
  end

  // ----------------------------------------------------------------
  // transmit frame build
  // ----------------------------------------------------------------
  logic [15:0] pwr_reg;                                  // power down bits
  logic [15:0] link_reg;                                 // link control
  logic        codec_ready;                              // software ready
  logic        req_n;                                    // slot 5 request, low
  logic        adc_on;                                   // slot 5 tag
  logic [15:0] adc_sample;                               // sample to send
  logic [15:0] tx_tag;                                   // slot 0 out
  logic [19:0] tx_s1;                                    // slot 1 out
  logic [19:0] tx_s2;                                    // slot 2 out
  logic [19:0] tx_s5;                                    // slot 5 out
  logic [19:0] tx_s12;                                   // slot 12 out
  logic [7:0]  gp_prev;                                  // last inputs sent
  logic [7:0]  gp_now;                                   // current inputs
  logic        status_go;                                // answer this frame
  assign pwr_reg  = regs[REG_POWER[6:1]];
  assign link_reg = regs[REG_LINK[6:1]];
  assign gp_now   = {1'b0, line_lvl[2], gpb_lvl, gpa_lvl, line_lvl[1], 1'b0, line_lvl[0], 1'b0};

  // request decided at frame start; only halt withholds it, dac power down leaves it asserted
  always_comb begin
    if (link_reg[LINK_HALT])                           req_n = 1'b1;
    else if (pwr_reg[PD_DAC_A] || pwr_reg[PD_DAC_B])   req_n = 1'b0;
    else                                               req_n = 1'b0;
    adc_on = !(pwr_reg[PD_ADC_A] || pwr_reg[PD_ADC_B] || link_reg[LINK_HALT]);
  end

  // latch the outgoing frame at its start
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_tag    <= 16'h0000;
      tx_s1     <= 20'h00000;
      tx_s2     <= 20'h00000;
      tx_s5     <= 20'h00000;
      tx_s12    <= 20'h00000;
      gp_prev   <= 8'h00;
      status_go <= 1'b0;
    end else if (frame_start) begin
      status_go <= cmd_pend;
      tx_tag    <= {codec_ready, cmd_pend, cmd_pend, 2'b00, codec_ready & adc_on, 6'h00,
                    codec_ready, 1'b0, 2'b00};
      tx_s1     <= cmd_pend ? {1'b0, cmd_idx, 2'b00, req_n, 4'hF, 1'b1, 4'h0}
                            : {10'h000, req_n, 4'hF, 1'b1, 4'h0};
      tx_s2     <= (cmd_pend && cmd_rd && !cmd_idx[0]) ? {regs[cmd_idx[6:1]], 4'h0} : 20'h00000;
      tx_s5     <= adc_on ? {adc_sample, 4'h0} : 20'h00000;
      tx_s12    <= {8'h00, gp_now, 2'b00, line_lvl[3], gp_now != gp_prev};
      gp_prev   <= gp_now;
    end
  end

  // serialiser: bit k of the frame driven on the rising edge after fall k-1
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sdata_in <= 1'b0;
    end else if (rise && rx_run) begin
      if (rx_pos < SLOT1_START)                          sdata_in <= tx_tag[4'(15 - rx_pos)];
      else if (rx_pos < SLOT2_START)                     sdata_in <= tx_s1[5'(SLOT2_START - 9'h001 - rx_pos)];
      else if (rx_pos < SLOT2_START + 9'(SLOT_BITS))     sdata_in <= tx_s2[5'(SLOT2_START + 9'h013 - rx_pos)];
      else if (rx_pos >= SLOT5_START && rx_pos < SLOT5_START + 9'(SLOT_BITS))
                                                         sdata_in <= tx_s5[5'(SLOT5_START + 9'h013 - rx_pos)];
      else if (rx_pos >= SLOT12_START && rx_pos < SLOT12_START + 9'(SLOT_BITS))
                                                         sdata_in <= tx_s12[5'(SLOT12_START + 9'h013 - rx_pos)];
      else                                               sdata_in <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // line interface outputs from slot 12
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line_off_hook           <= 1'b0;
      caller_info_path_enable <= 1'b0;
      line_iface_interrupt    <= 1'b0;
      gp_pin_a_out            <= 1'b0;
      gp_pin_b_out            <= 1'b0;
      gp_pin_a_oe_n           <= 1'b1;
      gp_pin_b_oe_n           <= 1'b1;
    end else begin
      line_off_hook           <= gp_ctrl[0];
      caller_info_path_enable <= gp_ctrl[2];
      line_iface_interrupt    <= gp_ctrl[7];
      gp_pin_a_out            <= gp_ctrl[4];
      gp_pin_b_out            <= gp_ctrl[5];
      gp_pin_a_oe_n           <= ~gp_ctrl[12];
      gp_pin_b_oe_n           <= ~gp_ctrl[13];
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite slave
  // ----------------------------------------------------------------
  logic       aw_held;                                   // address taken
  logic       w_held;                                    // data taken
  logic [7:0] aw_addr;                                   // held address
  logic [31:0] w_data;                                   // held data
  logic [3:0]  w_strb;                                   // held strobes

  // write channel: take address and data in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h00000000;
      w_strb  <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      codec_ready   <= 1'b0;
      adc_sample    <= 16'h0000;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid && s_axi_awvalid;
      s_axi_wready  <= !w_held && !s_axi_wready && !s_axi_bvalid && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (aw_held && w_held && !s_axi_bvalid) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= RESP_OKAY;
        if (aw_addr == AXI_CTRL) begin
          if (w_strb[0]) codec_ready <= w_data[0];
        end else if (aw_addr == AXI_ADC) begin
          if (w_strb[0]) adc_sample[7:0]  <= w_data[7:0];
          if (w_strb[1]) adc_sample[15:8] <= w_data[15:8];
        end else if (aw_addr != AXI_STATUS && aw_addr != AXI_DAC) begin
          s_axi_bresp <= RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read channel: one cycle to answer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= RESP_OKAY;
        if (s_axi_araddr == AXI_CTRL)        s_axi_rdata <= {31'h00000000, codec_ready};
        else if (s_axi_araddr == AXI_STATUS) s_axi_rdata <= {24'h000000, status_go, req_n, adc_on, rx_run,
                                                             gp_ctrl[2], gp_ctrl[0], gp_ctrl[7], rx_tag[TAG_FRAME]};
        else if (s_axi_araddr == AXI_ADC)    s_axi_rdata <= {16'h0000, adc_sample};
        else if (s_axi_araddr == AXI_DAC)    s_axi_rdata <= {16'h0000, dac_sample};
        else begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= RESP_SLVERR;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule : aclink_modem_slots

// *** bench/aclink_modem_slots_sva.sv ***
`timescale 1ns/1ps
module aclink_modem_slots_chk (
  input wire logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
  input wire logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic [1:0]  s_axi_bresp, s_axi_rresp,
  input wire logic [31:0] s_axi_rdata
);
  import aclink_modem_pkg::*;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence rd_hs; s_axi_arvalid && s_axi_arready; endsequence
  sequence wr_hs; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
  chk_aw_ready: assert property (s_axi_awvalid && !s_axi_awready |=> s_axi_awready) else $error("awready late");
  chk_w_ready: assert property (s_axi_wvalid && !s_axi_wready |=> s_axi_wready) else $error("wready late");
  chk_ar_ready: assert property (s_axi_arvalid && !s_axi_arready |=> s_axi_arready) else $error("arready late");
  chk_b_answer: assert property (wr_hs |-> ##2 s_axi_bvalid) else $error("bvalid late");
  chk_b_cause: assert property ($rose(s_axi_bvalid) |-> $past(s_axi_wvalid && s_axi_wready, 2))
    else $error("bvalid without write");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("bvalid dropped");
  chk_r_answer: assert property (rd_hs |=> s_axi_rvalid) else $error("rvalid late");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("rvalid dropped");
  chk_bad_read: assert property (rd_hs ##0 s_axi_araddr > 8'h0C |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read answered");
endmodule : aclink_modem_slots_chk
bind aclink_modem_slots aclink_modem_slots_chk u_chk (.*);

// *** bench/aclink_ctrl_model.sv ***
`timescale 1ns/1ps
// link controller; bit clock runs only inside frames
module aclink_ctrl_model (
  output logic     bit_clk,
  output logic     sync,
  output logic     sdata_out,
  input wire logic sdata_in
);
  initial {bit_clk, sync, sdata_out} = 3'h0;
  // drive on rise, sample input late in each bit
  task automatic frame(input logic [255:0] o, output logic [255:0] i);
    for (int k = 0; k <= 256; k++) begin
      bit_clk = 1'h1;
      sync = (k < 16);
      sdata_out = (k > 0) ? o[256-k] : 1'h0;
      #400 bit_clk = 1'h0;
      #350 if (k > 0) i[256-k] = sdata_in;
      #50;
    end
    sdata_out = 1'h0;
  endtask : frame
endmodule : aclink_ctrl_model

// *** bench/aclink_secondary_modem_slots_bench.sv ***
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_count++; $display("CHECK FAILED t=%0t mismatch", $time); end end
module aclink_secondary_modem_slots_bench;
  import aclink_modem_pkg::*;
  logic aclk = '0, aresetn = '0, awv = '0, wv = '0, bre = '0, arv = '0, rre = '0;
  logic [7:0] awa = '0, ara = '0;
  logic [31:0] wd = '0, rd, v;
  logic [1:0] br, rr, rsp;
  logic bv, awr, wr, arr, rv, bck, syn, sdo, sdi, aoe, aout, boe, bout, hook, cid, dint;
  logic [255:0] ib;
  int err_count = 0, n_tests = 0, cyc = 0;
  always #50 aclk = ~aclk;
  // gpio pins pulled up when not driven
  aclink_modem_slots dut (.aclk(aclk), .aresetn(aresetn), .bit_clk(bck), .sync(syn), .sdata_out(sdo),
    .sdata_in(sdi), .line_off_hook(hook), .caller_info_path_enable(cid), .line_iface_interrupt(dint),
    .gp_pin_a_out(aout), .gp_pin_a_oe_n(aoe), .gp_pin_b_out(bout), .gp_pin_b_oe_n(boe),
    .gp_pin_a_in(aoe | aout), .gp_pin_b_in(boe | bout), .ring_detected(1'h1), .loop_current_delta(1'h0),
    .loop_current_overload(1'h0), .line_side_frame_detect(1'h1), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre));
  aclink_ctrl_model ctl (.bit_clk(bck), .sync(syn), .sdata_out(sdo), .sdata_in(sdi));
  // register write, address and data offered together
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic pa, pd;
    @(posedge aclk);
    {pa, pd} = 2'h3;
    awa <= a; wd <= d; awv <= 1'h1; wv <= 1'h1; bre <= 1'h1;
    while (pa | pd) begin
      @(posedge aclk);
      if (pa & awr) begin pa = 1'h0; awv <= 1'h0; end
      if (pd & wr) begin pd = 1'h0; wv <= 1'h0; end
    end
    while (bv !== 1'h1) @(posedge aclk);
    rsp = br; bre <= 1'h0;
  endtask : axw
  // register read
  task automatic axr(input logic [7:0] a);
    @(posedge aclk);
    ara <= a; arv <= 1'h1; rre <= 1'h1;
    do @(posedge aclk); while (arr !== 1'h1);
    arv <= 1'h0;
    while (rv !== 1'h1) @(posedge aclk);
    v = rd; rsp = rr; rre <= 1'h0;
  endtask : axr
  // one link frame: tag, index, read flag, data, dac sample, slot 12
  task automatic fr(input logic [15:0] t, input logic [6:0] x, input logic r, input logic [15:0] d, s5, s12);
    #37 ctl.frame({t, r, x, 12'h0, d, 4'h0, 40'h0, s5, 4'h0, 120'h0, s12, 4'h0}, ib);
  endtask : fr
  task automatic give_verdict;
    $display("mismatches %0d comparisons %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : give_verdict
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin err_count++; give_verdict; end
  end
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    fr(16'h8000, 7'h00, 1'h0, 16'h0, 16'h0, 16'h0);
    `CHK(ib[255], 1'h0)
    axw(AXI_CTRL, 32'h1);
    axw(AXI_ADC, 32'hA5C3);
    `CHK(rsp, RESP_OKAY)
    axr(AXI_CTRL);
    `CHK({rsp, v}, {RESP_OKAY, 32'h1})
    axr(8'h10);
    `CHK(rsp, RESP_SLVERR)
    fr(16'h8001, 7'h3F, 1'h0, 16'hFFFF, 16'h0, 16'h0);
    `CHK(ib[255], 1'h1)
    fr(16'h8001, 7'h3F, 1'h1, 16'h0, 16'h0, 16'h0);
    `CHK({ib[255:253], ib[241:240]}, 5'h1C)
    `CHK({ib[250], ib[229], ib[159:140]}, 22'h2A5C30)
    `CHK({ib[5], ib[1]}, 2'h3)
    fr(16'h0001, 7'h3E, 1'h0, 16'h0800, 16'h0, 16'h0);
    `CHK({ib[238:232], ib[219:200]}, {7'h3F, 20'h0})
    fr(16'h8409, 7'h3E, 1'h0, 16'h0400, 16'h1234, 16'h1095);
    axr(AXI_DAC);
    `CHK(v[15:0], 16'h1234)
    fr(16'h8001, 7'h3E, 1'h1, 16'h0, 16'h0, 16'h0);
    `CHK({ib[250], hook, cid, dint, aoe, aout, boe, bout}, 8'h76)
    fr(16'h8001, 7'h56, 1'h0, 16'h1000, 16'h0, 16'h0);
    `CHK({ib[238:232], ib[219:200]}, {7'h3E, 20'h04000})
    fr(16'h8000, 7'h00, 1'h0, 16'h0, 16'h0, 16'h0);
    `CHK(ib[229], 1'h1)
    give_verdict;
  end
endmodule : aclink_secondary_modem_slots_bench
